// file: hw/pfs_defines.svh
// Offsets, field positions and reset values of the pin function select block
`ifndef PFS_DEFINES_SVH
`define PFS_DEFINES_SVH
`define PFS_EXT_INDEX 8'h14
`define PFS_MEM_OFFSET 12'h914
`define PFS_F1_LSB 0
`define PFS_F2_LSB 2
`define PFS_F3_LSB 4
`define PFS_F4_LSB 6
`define PFS_RESET_VAL 8'h00
`endif

// file: hw/pfs_pkg.sv
// Types for the pin function select block
package pfs_pkg;
    typedef enum logic [1:0] {
        PFS_SEL_NATIVE,
        PFS_SEL_GPIO,
        PFS_SEL_ALT,
        PFS_SEL_BAD
    } pfs_sel_t;
    typedef struct packed {
        logic [7:0] data;
        logic wr;
        logic rd;
    } pfs_acc_t;
    typedef struct packed {
        logic out;
        logic oe;
    } pfs_pin_t;
endpackage : pfs_pkg

// file: hw/pfs_pin_route.sv
// One multiplexed pin: picks its source from the select code
module pfs_pin_route
    import pfs_pkg::*;
(
    // Select and sources
    input wire logic [1:0] sel,
    input wire logic native_out,
    input wire logic native_oe,
    input wire logic alt_out,
    input wire logic alt_oe,
    input wire logic gpio_out,
    input wire logic gpio_oe,
    // Routed pin
    output pfs_pin_t pin,
    output logic gpio_sel
);
    always_comb begin
        pin = '{out: 1'b0, oe: 1'b0};
        gpio_sel = 1'b0;
        case (pfs_sel_t'(sel))
            PFS_SEL_NATIVE: pin = '{out: native_out, oe: native_oe};
            PFS_SEL_GPIO: begin
                pin = '{out: gpio_out, oe: gpio_oe};
                gpio_sel = 1'b1;
            end
            PFS_SEL_ALT: pin = '{out: alt_out, oe: alt_oe};
            // Forbidden code: pin left undriven, safest choice
            default: pin = '{out: 1'b0, oe: 1'b0};
        endcase
    end
endmodule : pfs_pin_route

// file: hw/pfs_pin_function_select.sv
// Chip-wide pin function select register and pin routing
`include "pfs_defines.svh"

//Contract
// - Bits 3:2 at zero route pin two to serial input, serialized data or socket B indicator, at 01 to general line two; the code never drives serialized data.
// - With power-event enable set, a software reset on the D3 to D0 change keeps every register bit.
// - As indicator, the socket A pin is open-drain active low, or the combined indicator in single mode.
// - As indicator, the socket B pin is open-drain active low, or the combined indicator when dual socket is 0.
// - The socket indicator functions of pins one and two exist only in the PCI/Way interrupt mode; pin four's combined indicator exists in both.
// - One register per chip at extended index 14h or memory offset 914h, the latter for function 0 only.
// - Bits 5:4 at zero route pin three to the speaker, at 01 to general line three.
// - Bits 7:6 at zero give indicator or suspend input, 01 general line four, 10 the power-event output.
module pfs_pin_function_select
    import pfs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Software bus-segment reset on a D3 to D0 change
    input wire logic soft_seg_reset,
    input wire logic power_event_enable,
    // Indexed window access
    input wire logic ext_wr,
    input wire logic ext_rd,
    input wire logic [7:0] ext_index,
    input wire logic [7:0] ext_wdata,
    // Memory access
    input wire logic mem_wr,
    input wire logic mem_rd,
    input wire logic [11:0] mem_offset,
    input wire logic [2:0] mem_function,
    input wire logic [7:0] mem_wdata,
    // Read data
    output logic [7:0] rdata,
    output logic rvalid,
    // Configuration from elsewhere in the chip
    input wire logic pciway_mode,
    input wire logic dual_socket,
    // Native sources, active low where indicators
    input wire logic inta_n,
    input wire logic socket_a_indicator,
    input wire logic socket_b_indicator,
    input wire logic combined_activity_indicator,
    input wire logic serialized_data_line,
    input wire logic speaker_output,
    input wire logic pme_n,
    input wire logic [3:0] gpio_out,
    input wire logic [3:0] gpio_oe,
    // Pins, three signals each
    input wire logic [3:0] pin_in,
    output logic [3:0] pin_out,
    output logic [3:0] pin_oe,
    // Received functions and selections
    output logic serial_interrupt_input,
    output logic hardware_suspend_input,
    output logic [3:0] gpio_in,
    output logic [3:0] gpio_selected,
    output logic [7:0] select_value
);
    logic [7:0] sel_r;
    logic [3:0] pin_s1_r;
    logic [3:0] pin_s2_r;
    logic [7:0] rdata_r;
    logic rvalid_r;
    pfs_pin_t [3:0] route;
    logic [3:0] gsel;
    logic hit_ext;
    logic hit_mem;
    logic a_ind;
    logic b_ind;
    logic nat1_out, nat1_oe, nat2_out, nat2_oe;

    function automatic logic mem_hit(input logic [11:0] off,
                                     input logic [2:0] fn);
        mem_hit = (off == `PFS_MEM_OFFSET) && (fn == 3'h0);
    endfunction : mem_hit

    assign hit_ext = (ext_index == `PFS_EXT_INDEX);
    assign hit_mem = mem_hit(mem_offset, mem_function);

    // Software writes; forbidden codes stored as written, software's duty
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sel_r <= `PFS_RESET_VAL;
        end else if (soft_seg_reset) begin
            // Context kept while power-event enable is set
            if (!power_event_enable) begin
                sel_r <= `PFS_RESET_VAL;
            end
        end else if (ext_wr && hit_ext) begin
            sel_r <= ext_wdata;
        end else if (mem_wr && hit_mem) begin
            sel_r <= mem_wdata;
        end
    end

    // Read path, one cycle latency
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_r <= 8'h00;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= (ext_rd && hit_ext) || (mem_rd && hit_mem);
            if (ext_rd && hit_ext) begin
                rdata_r <= sel_r;
            end else if (mem_rd && hit_mem) begin
                rdata_r <= sel_r;
            end else begin
                rdata_r <= 8'h00;
            end
        end
    end

    // Pin inputs arrive from outside, two stages
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_s1_r <= 4'hF;
            pin_s2_r <= 4'hF;
        end else begin
            pin_s1_r <= pin_in;
            pin_s2_r <= pin_s1_r;
        end
    end

    // Indicator either per socket or the combined one
    assign a_ind = dual_socket ? socket_a_indicator
                               : combined_activity_indicator;
    assign b_ind = dual_socket ? socket_b_indicator
                               : combined_activity_indicator;

    // Open drain: drive only the low level
    always_comb begin
        if (pciway_mode) begin
            nat1_out = 1'b0;
            nat1_oe = !a_ind;
            nat2_out = 1'b0;
            nat2_oe = !b_ind;
        end else begin
            nat1_out = 1'b0;
            nat1_oe = !inta_n;
            nat2_out = serialized_data_line;
            nat2_oe = 1'b0;
        end
    end

    pfs_pin_route u_pin1 (
        .sel(sel_r[`PFS_F1_LSB +: 2]),
        .native_out(nat1_out), .native_oe(nat1_oe),
        .alt_out(1'b0), .alt_oe(1'b0),
        .gpio_out(gpio_out[0]), .gpio_oe(gpio_oe[0]),
        .pin(route[0]), .gpio_sel(gsel[0])
    );
    pfs_pin_route u_pin2 (
        .sel(sel_r[`PFS_F2_LSB +: 2]),
        .native_out(nat2_out), .native_oe(nat2_oe),
        .alt_out(1'b0), .alt_oe(1'b0),
        .gpio_out(gpio_out[1]), .gpio_oe(gpio_oe[1]),
        .pin(route[1]), .gpio_sel(gsel[1])
    );
    pfs_pin_route u_pin3 (
        .sel(sel_r[`PFS_F3_LSB +: 2]),
        .native_out(speaker_output), .native_oe(1'b1),
        .alt_out(1'b0), .alt_oe(1'b0),
        .gpio_out(gpio_out[2]), .gpio_oe(gpio_oe[2]),
        .pin(route[2]), .gpio_sel(gsel[2])
    );
    pfs_pin_route u_pin4 (
        .sel(sel_r[`PFS_F4_LSB +: 2]),
        .native_out(1'b0),
        .native_oe(dual_socket ? 1'b0 : !combined_activity_indicator),
        .alt_out(1'b0), .alt_oe(!pme_n),
        .gpio_out(gpio_out[3]), .gpio_oe(gpio_oe[3]),
        .pin(route[3]), .gpio_sel(gsel[3])
    );

    // Registered pin drive, one cycle behind the sources
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_out <= 4'h0;
            pin_oe <= 4'h0;
            gpio_selected <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                pin_out[i] <= route[i].out;
                pin_oe[i] <= route[i].oe;
            end
            gpio_selected <= gsel;
        end
    end

    // Inputs received only when their function is selected
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            serial_interrupt_input <= 1'b1;
            hardware_suspend_input <= 1'b1;
            gpio_in <= 4'hF;
        end else begin
            serial_interrupt_input <= (sel_r[3:2] == 2'b00 && !pciway_mode)
                ? pin_s2_r[1] : 1'b1;
            // Suspend input only while pin four is not driving an indicator
            hardware_suspend_input <= (sel_r[7:6] == 2'b00 && dual_socket)
                ? pin_s2_r[3] : 1'b1;
            for (int i = 0; i < 4; i++) begin
                gpio_in[i] <= gsel[i] ? pin_s2_r[i] : 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            select_value <= `PFS_RESET_VAL;
        end else begin
            select_value <= sel_r;
        end
    end

    assign rdata = rdata_r;
    assign rvalid = rvalid_r;
endmodule : pfs_pin_function_select

// file: tb/pfs_props.sv
// Checker for the pin function select block
module pfs_props
    import pfs_pkg::*;
(
    // Clock, reset and access
    input wire logic clk, nrst, soft_seg_reset, power_event_enable,
    input wire logic ext_wr, mem_wr,
    input wire logic [7:0] ext_index, ext_wdata, mem_wdata, select_value,
    input wire logic [11:0] mem_offset,
    input wire logic [2:0] mem_function,
    // Sources and pins
    input wire logic pciway_mode, dual_socket, socket_a_indicator,
    input wire logic speaker_output, pme_n,
    input wire logic [3:0] pin_out, pin_oe
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!nrst);
    logic xh, mh;
    assign xh = ext_wr && ext_index == 8'h14;
    assign mh = mem_wr && mem_offset == 12'h914 && mem_function == 3'h0;
    // Copy port lags the register by one more edge
    property p_ext;
        xh && !soft_seg_reset |=> ##1 select_value == $past(ext_wdata, 2);
    endproperty
    a_ext: assert property (p_ext) else $error("index write lost");
    property p_mem;
        mh && !xh && !soft_seg_reset |=> ##1
            select_value == $past(mem_wdata, 2);
    endproperty
    a_mem: assert property (p_mem) else $error("memory write lost");
    property p_hold;
        !xh && !mh && !soft_seg_reset |=> ##1 $stable(select_value);
    endproperty
    a_hold: assert property (p_hold) else $error("stray change");
    property p_keep;
        soft_seg_reset && power_event_enable |=> ##1 $stable(select_value);
    endproperty
    a_keep: assert property (p_keep) else $error("context lost");
    property p_clr;
        soft_seg_reset && !power_event_enable |=> ##1 select_value == 8'h00;
    endproperty
    a_clr: assert property (p_clr) else $error("not cleared");
    property p_spk;
        // Pins and copy port both hold last edge's register
        select_value[5:4] == 2'b00 && $past(nrst) |->
            pin_oe[2] && pin_out[2] == $past(speaker_output);
    endproperty
    a_spk: assert property (p_spk) else $error("speaker pin");
    property p_pme;
        select_value[7:6] == 2'b10 && $past(nrst) |->
            pin_oe[3] == !$past(pme_n) && !pin_out[3];
    endproperty
    a_pme: assert property (p_pme) else $error("event pin");
    property p_ind;
        select_value[1:0] == 2'b00 && $past(pciway_mode) &&
            $past(dual_socket) && $past(nrst) |->
            pin_oe[0] == !$past(socket_a_indicator) && !pin_out[0];
    endproperty
    a_ind: assert property (p_ind) else $error("indicator pin");
endmodule : pfs_props
bind pfs_pin_function_select pfs_props u_props (.*);

// file: tb/pfs_board.sv
// Board model: pull-ups on the four multiplexed pins
module pfs_board (
    // Pins from the chip
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe,
    // Other board parts pulling a released pin low
    input wire logic [3:0] board_low,
    // Levels on the board
    output logic [3:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // Released pins go to the pull-up unless board_low pulls them low, never to the last value
    assign pin_in = (pin_out & pin_oe) | (~pin_oe & ~board_low);
endmodule : pfs_board

// file: tb/tb_pin_function_select_control.sv
// Testbench of the pin function select block
module tb_pin_function_select_control;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, nrst, soft_seg_reset, power_event_enable, ext_wr, ext_rd;
    logic mem_wr, mem_rd, rvalid, pciway_mode, dual_socket, inta_n;
    logic socket_a_indicator, socket_b_indicator, pme_n, speaker_output;
    logic combined_activity_indicator, serialized_data_line;
    logic serial_interrupt_input, hardware_suspend_input;
    logic [7:0] ext_index, ext_wdata, mem_wdata, rdata, select_value, v;
    logic [11:0] mem_offset;
    logic [2:0] mem_function;
    logic [3:0] gpio_out, gpio_oe, pin_in, pin_out, pin_oe, gpio_in;
    logic [3:0] gpio_selected, board_low;
    logic [31:0] seed, r;
    int errors, checks;
    pfs_pin_function_select uut (.*);
    pfs_board board (.*);
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: %h %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    // Software never programs the forbidden codes
    function automatic logic [7:0] legal(input logic [7:0] d);
        legal = d & 8'hD5;
        if (d[7:6] == 2'b11) legal[7:6] = 2'b10;
    endfunction : legal
    function automatic logic [3:0] gsel(input logic [7:0] d);
        for (int k = 0; k < 4; k++) gsel[k] = d[2*k+:2] == 2'b01;
    endfunction : gsel
    task automatic wr(input bit m, input logic [11:0] a, input logic [2:0] f,
                      input logic [7:0] d);
        @(negedge clk);
        if (m) {mem_wr, mem_offset, mem_function, mem_wdata} = {1'b1, a, f, d};
        else {ext_wr, ext_index, ext_wdata} = {1'b1, a[7:0], d};
        @(negedge clk);
        {ext_wr, mem_wr} = 2'b00;
    endtask : wr
    task automatic rd(input bit m, input logic [7:0] e);
        @(negedge clk);
        if (m) {mem_rd, mem_offset, mem_function} = {1'b1, 12'h914, 3'h0};
        else {ext_rd, ext_index} = {1'b1, 8'h14};
        @(negedge clk);
        {ext_rd, mem_rd} = 2'b00;
        chk({7'h00, rvalid}, 8'h01);
        chk(rdata, e);
    endtask : rd
    task automatic complete_run();
        if (errors == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Run needs about 212 cycles; the 500-cycle limit marks a hang
    initial begin
        #20000;
        errors++;
        complete_run();
    end
    initial begin
        seed = 32'h75E8635E;
        {nrst, soft_seg_reset, power_event_enable, ext_wr, ext_rd} = 5'h00;
        {mem_wr, mem_rd, pciway_mode, dual_socket} = 4'h0;
        serialized_data_line = 1'b0;
        board_low = 4'h0;
        {inta_n, socket_a_indicator, socket_b_indicator, pme_n} = 4'hF;
        {combined_activity_indicator, speaker_output} = 2'b11;
        {ext_index, ext_wdata, mem_wdata} = 24'h000000;
        {mem_offset, mem_function, gpio_out, gpio_oe} = 23'h000000;
        repeat (7) @(negedge clk);
        nrst = 1'b1;
        rd(1'b0, 8'h00);
        chk({6'h00, pin_oe[2], pin_out[2]}, 8'h03);
        for (int i = 0; i < 24; i++) begin
            r = xs();
            v = legal(r[7:0]);
            {gpio_out, gpio_oe, speaker_output, pme_n} = r[31:22];
            wr(r[8], r[8] ? 12'h914 : 12'h014, 3'h0, v);
            rd(r[9], v);
            chk({4'h0, gpio_selected}, {4'h0, gsel(v)});
            chk({4'h0, pin_oe & gsel(v)}, {4'h0, gpio_oe & gsel(v)});
            chk({4'h0, pin_out & gsel(v)},
                {4'h0, gpio_out & gsel(v)});
            // Pin drive has settled; level needs the two sync stages and the gpio_in register
            repeat (3) @(negedge clk);
            chk({4'h0, gpio_in},
                {4'h0, ~gsel(v) | ~gpio_oe | gpio_out});
        end
        // Wrong function, offset or index must leave it alone
        wr(1'b1, 12'h914, 3'h1, 8'h11);
        wr(1'b1, 12'h915, 3'h0, 8'h11);
        wr(1'b0, 12'h015, 3'h0, 8'h11);
        rd(1'b1, v);
        wr(1'b0, 12'h014, 3'h0, 8'h80);
        {pciway_mode, dual_socket, socket_a_indicator, pme_n} = 4'b1100;
        repeat (2) @(negedge clk);
        chk({4'h0, pin_oe}, 8'h0D);
        {dual_socket, combined_activity_indicator} = 2'b00;
        repeat (2) @(negedge clk);
        chk({4'h0, pin_oe}, 8'h0F);
        pciway_mode = 1'b0;
        repeat (2) @(negedge clk);
        chk({4'h0, pin_oe}, 8'h0C);
        {power_event_enable, soft_seg_reset} = 2'b11;
        repeat (2) @(negedge clk);
        chk(select_value, 8'h80);
        power_event_enable = 1'b0;
        @(negedge clk);
        soft_seg_reset = 1'b0;
        @(negedge clk);
        chk(select_value, 8'h00);
        // Bus reset in mid-run clears a written value
        wr(1'b0, 12'h014, 3'h0, 8'h55);
        rd(1'b0, 8'h55);
        nrst = 1'b0;
        @(negedge clk);
        nrst = 1'b1;
        rd(1'b1, 8'h00);
        // Received functions, with board parts pulling pins low
        {dual_socket, inta_n, board_low} = 6'b101010;
        repeat (4) @(negedge clk);
        chk({4'h0, pin_oe}, 8'h05);
        v = {6'h00, serial_interrupt_input, hardware_suspend_input};
        chk(v, 8'h00);
        {inta_n, board_low} = 5'h10;
        repeat (4) @(negedge clk);
        v = {6'h00, serial_interrupt_input, hardware_suspend_input};
        chk(v, 8'h03);
        complete_run();
    end
endmodule : tb_pin_function_select_control
